// ===== src/paru_regs.svh
`ifndef PARU_REGS_SVH
`define PARU_REGS_SVH

`define PARU_NUM_SETS      3
`define PARU_PAGES_PER_SET 16
`define PARU_NUM_PAGES     48
`define PARU_VA_W          16
`define PARU_PA_W          18
`define PARU_BASE_W        12
`define PARU_BLK_SHIFT     6
`define PARU_DISP_W        13
`define PARU_LEN_W         7

`define PARU_BASE_OFF      8'h00
`define PARU_DESC_OFF      8'h40
`define PARU_CTRL_OFF      8'h80
`define PARU_STAT_OFF      8'h81

`define PARU_DESC_KEY_LSB  0
`define PARU_DESC_ACC_BIT  6
`define PARU_DESC_WR_BIT   7
`define PARU_DESC_LEN_LSB  8
`define PARU_CTRL_EN_BIT   0

`define PARU_KEY_NONRES    2'h0
`define PARU_KEY_RDONLY    2'h1
`define PARU_KEY_XONLY     2'h2
`define PARU_KEY_RDWR      2'h3

`define PARU_MODE_KERNEL   2'h0
`define PARU_MODE_SUPER    2'h1
`define PARU_MODE_USER     2'h3

`define PARU_RST_BASE      12'h000
`define PARU_RST_LEN       7'h00
`define PARU_RST_KEY       2'h0
`define PARU_RST_CTRL      1'h0

`endif

// ===== src/paru_pkg.sv
package paru_pkg;
  typedef struct packed {
    logic [11:0] base;
    logic [6:0]  len;
    logic [1:0]  key;
    logic        acc;
    logic        wr;
  } paru_entry_t;

  typedef struct packed {
    logic        valid;
    logic [15:0] va;
    logic [1:0]  mode;
    logic        write;
    logic        inst;
  } paru_req_t;

  typedef struct packed {
    logic        valid;
    logic        abort;
    logic [17:0] pa;
  } paru_resp_t;
endpackage

// ===== src/paru_page_entry.sv
`include "paru_regs.svh"

module paru_page_entry
  import paru_pkg::*;
(
  input  wire logic        core_clk_i,
  input  wire logic        resetn_i,
  input  wire logic        base_we_i,
  input  wire logic        desc_we_i,
  input  wire logic [15:0] wdata_i,
  input  wire logic        set_acc_i,
  input  wire logic        set_wr_i,
  output paru_entry_t      entry_o
);
  logic [11:0] base_q;
  logic [6:0]  len_q;
  logic [1:0]  key_q;
  logic        acc_q;
  logic        wr_q;

  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      base_q <= `PARU_RST_BASE;
    end else if (base_we_i) begin
      base_q <= wdata_i[`PARU_BASE_W-1:0];
    end
  end

  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      len_q <= `PARU_RST_LEN;
      key_q <= `PARU_RST_KEY;
    end else if (desc_we_i) begin
      len_q <= wdata_i[`PARU_DESC_LEN_LSB +: `PARU_LEN_W];
      key_q <= wdata_i[`PARU_DESC_KEY_LSB +: 2];
    end
  end

  // hardware set wins over a software write of zero
  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      acc_q <= 1'b0;
      wr_q  <= 1'b0;
    end else begin
      acc_q <= set_acc_i | (desc_we_i ? wdata_i[`PARU_DESC_ACC_BIT] : acc_q);
      wr_q  <= set_wr_i | (desc_we_i ? wdata_i[`PARU_DESC_WR_BIT] : wr_q);
    end
  end

  assign entry_o = '{base: base_q, len: len_q, key: key_q, acc: acc_q, wr: wr_q};
endmodule

// ===== src/paru_key_check.sv
`include "paru_regs.svh"

module paru_key_check
  import paru_pkg::*;
(
  input  wire logic [1:0] key_i,
  input  wire logic [6:0] len_i,
  input  wire logic [6:0] block_i,
  input  wire logic       write_i,
  input  wire logic       inst_i,
  output logic            key_ok_o,
  output logic            len_ok_o
);
  always_comb begin
    key_ok_o = 1'b0;
    unique case (key_i)
      `PARU_KEY_NONRES: key_ok_o = 1'b0;
      `PARU_KEY_RDONLY: key_ok_o = !write_i;
      `PARU_KEY_XONLY:  key_ok_o = inst_i && !write_i;
      `PARU_KEY_RDWR:   key_ok_o = 1'b1;
    endcase
  end

  // length counts 64-word blocks minus one, so 0..127 covers 64..8192 words
  assign len_ok_o = (block_i <= len_i);
endmodule

// ===== src/paru_top.sv
`include "paru_regs.svh"

module paru_top
  import paru_pkg::*;
(
  input  wire logic        core_clk_i,
  input  wire logic        resetn_i,
  input  paru_req_t        req_i,
  output paru_resp_t       resp_o,
  input  wire logic [7:0]  reg_addr_i,
  input  wire logic [15:0] reg_wdata_i,
  input  wire logic        reg_we_i,
  input  wire logic        reg_re_i,
  output logic [15:0]      reg_rdata_o
);
  paru_entry_t entry_w [`PARU_NUM_PAGES];
  logic [`PARU_NUM_PAGES-1:0] base_we;
  logic [`PARU_NUM_PAGES-1:0] desc_we;
  logic [`PARU_NUM_PAGES-1:0] set_acc;
  logic [`PARU_NUM_PAGES-1:0] set_wr;

  logic        reloc_en_q;
  logic [2:0]  stat_q;
  logic [15:0] rdata_q;
  paru_resp_t  resp_q;

  logic        mode_ok;
  logic [1:0]  set_sel;
  logic [5:0]  sel_idx;
  paru_entry_t sel_e;
  logic [17:0] pa_sum;
  logic        key_ok;
  logic        len_ok;
  logic        allow;
  logic        hit;
  logic        deny;

  // address decode for the page tables
  genvar gi;
  generate
    for (gi = 0; gi < `PARU_NUM_PAGES; gi++) begin : g_page
      assign base_we[gi] = reg_we_i && (reg_addr_i == 8'(`PARU_BASE_OFF + gi));
      assign desc_we[gi] = reg_we_i && (reg_addr_i == 8'(`PARU_DESC_OFF + gi));
      assign set_acc[gi] = hit && (sel_idx == 6'(gi));
      assign set_wr[gi]  = hit && req_i.write && (sel_idx == 6'(gi));

      paru_page_entry u_entry (
        .core_clk_i (core_clk_i),
        .resetn_i   (resetn_i),
        .base_we_i  (base_we[gi]),
        .desc_we_i  (desc_we[gi]),
        .wdata_i    (reg_wdata_i),
        .set_acc_i  (set_acc[gi]),
        .set_wr_i   (set_wr[gi]),
        .entry_o    (entry_w[gi])
      );
    end
  endgenerate

  // page selection: mode set, then I/D subset, then top three address bits
  assign mode_ok = (req_i.mode != 2'h2);
  assign set_sel = req_i.mode[1] ? 2'h2 : {1'b0, req_i.mode[0]};
  assign sel_idx = {set_sel, !req_i.inst, req_i.va[15:13]};
  assign sel_e   = entry_w[sel_idx];

  // base in 64-word blocks plus 13-bit displacement, result modulo 2^18
  assign pa_sum = {sel_e.base, 6'h00} + {5'h00, req_i.va[12:0]};

  paru_key_check u_check (
    .key_i    (sel_e.key),
    .len_i    (sel_e.len),
    .block_i  (req_i.va[12:6]),
    .write_i  (req_i.write),
    .inst_i   (req_i.inst),
    .key_ok_o (key_ok),
    .len_ok_o (len_ok)
  );

  assign allow = mode_ok && key_ok && len_ok;
  assign hit   = req_i.valid && reloc_en_q && allow;
  assign deny  = req_i.valid && reloc_en_q && !allow;

  // translated reference, one cycle after the request
  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      resp_q <= '0;
    end else begin
      resp_q.valid <= req_i.valid && (!reloc_en_q || allow);
      resp_q.abort <= deny;
      resp_q.pa    <= reloc_en_q ? pa_sum : {2'h0, req_i.va};
    end
  end

  assign resp_o = resp_q;

  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      reloc_en_q <= `PARU_RST_CTRL;
    end else if (reg_we_i && (reg_addr_i == `PARU_CTRL_OFF)) begin
      reloc_en_q <= reg_wdata_i[`PARU_CTRL_EN_BIT];
    end
  end

  // outcome of the last reference made with relocation enabled: abort, key or mode violation, length violation
  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      stat_q <= 3'h0;
    end else if (req_i.valid && reloc_en_q) begin
      stat_q <= {!len_ok, !(key_ok && mode_ok), !allow};
    end
  end

  // register read port, data valid in the following cycle only
  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      rdata_q <= 16'h0000;
    end else if (!reg_re_i) begin
      rdata_q <= 16'h0000;
    end else if (reg_addr_i < 8'(`PARU_BASE_OFF + `PARU_NUM_PAGES)) begin
      rdata_q <= {4'h0, entry_w[6'(reg_addr_i - `PARU_BASE_OFF)].base};
    end else if ((reg_addr_i >= `PARU_DESC_OFF) && (reg_addr_i < 8'(`PARU_DESC_OFF + `PARU_NUM_PAGES))) begin
      rdata_q <= {1'b0, entry_w[6'(reg_addr_i - `PARU_DESC_OFF)].len,
                  entry_w[6'(reg_addr_i - `PARU_DESC_OFF)].wr,
                  entry_w[6'(reg_addr_i - `PARU_DESC_OFF)].acc,
                  4'h0, entry_w[6'(reg_addr_i - `PARU_DESC_OFF)].key};
    end else if (reg_addr_i == `PARU_CTRL_OFF) begin
      rdata_q <= {15'h0000, reloc_en_q};
    end else if (reg_addr_i == `PARU_STAT_OFF) begin
      rdata_q <= {13'h0000, stat_q};
    end else begin
      rdata_q <= 16'h0000;
    end
  end

  assign reg_rdata_o = rdata_q;

  default clocking cb @(posedge core_clk_i);
  endclocking
  default disable iff (!resetn_i);

  reloc_sum_a: assert property (
    hit |=> resp_o.valid && (resp_o.pa == 18'({$past(sel_e.base), 6'h00} + {5'h00, $past(req_i.va[12:0])})))
    else $error("relocated address is not base plus displacement");

  pass_thru_a: assert property (
    (req_i.valid && !reloc_en_q) |=> resp_o.valid && !resp_o.abort && (resp_o.pa == {2'h0, $past(req_i.va)}))
    else $error("disabled unit did not pass the address through");

  nonres_deny_a: assert property (
    (req_i.valid && reloc_en_q && (sel_e.key == `PARU_KEY_NONRES)) |=> resp_o.abort && !resp_o.valid)
    else $error("non-resident page was not denied");

  rdonly_write_a: assert property (
    (req_i.valid && reloc_en_q && (sel_e.key == `PARU_KEY_RDONLY) && req_i.write) |=> resp_o.abort)
    else $error("write to read-only page was not denied");

  xonly_data_a: assert property (
    (req_i.valid && reloc_en_q && (sel_e.key == `PARU_KEY_XONLY) && !req_i.inst) |=> resp_o.abort)
    else $error("data reference to execute-only page was not denied");

  len_limit_a: assert property (
    (req_i.valid && reloc_en_q && (req_i.va[12:6] > sel_e.len)) |=> resp_o.abort)
    else $error("reference beyond page length was not denied");

  abort_excl_a: assert property (
    !(resp_o.abort && resp_o.valid))
    else $error("aborted reference forwarded as valid");

  dspace_only_a: assert property (
    (req_i.valid && !req_i.inst) |-> sel_idx[3])
    else $error("data reference selected an instruction base");

  mode_sep_a: assert property (
    (req_i.valid && (req_i.mode == `PARU_MODE_USER)) |-> (sel_idx[5:4] == 2'h2))
    else $error("user reference left the user page set");

  acc_set_a: assert property (
    hit |=> entry_w[$past(sel_idx)].acc)
    else $error("accessed flag not set by a reference");

  wr_hold_a: assert property (
    (hit && !req_i.write && !desc_we[sel_idx]) |=> (entry_w[$past(sel_idx)].wr == $past(sel_e.wr)))
    else $error("written flag changed by a read");

  deny_hold_a: assert property (
    (deny && !desc_we[sel_idx]) |=>
      (entry_w[$past(sel_idx)].acc == $past(sel_e.acc)) && (entry_w[$past(sel_idx)].wr == $past(sel_e.wr)))
    else $error("denied reference changed page flags");

  rd_idle_a: assert property (
    !reg_re_i |=> (reg_rdata_o == 16'h0000))
    else $error("read data not zero outside the read answer cycle");

  // page selection and low address bits
  kernel_set_a: assert property (
    (req_i.valid && (req_i.mode == `PARU_MODE_KERNEL)) |-> (sel_idx[5:4] == 2'h0))
    else $error("kernel reference left the kernel page set");

  super_set_a: assert property (
    (req_i.valid && (req_i.mode == `PARU_MODE_SUPER)) |-> (sel_idx[5:4] == 2'h1))
    else $error("supervisor reference left the supervisor page set");

  ispace_sel_a: assert property (
    (req_i.valid && req_i.inst) |-> !sel_idx[3])
    else $error("instruction reference selected a data base");

  page_index_a: assert property (
    req_i.valid |-> (sel_idx[2:0] == req_i.va[15:13]))
    else $error("page index is not the top three address bits");

  pa_low_a: assert property (
    hit |=> (resp_o.pa[5:0] == $past(req_i.va[5:0])))
    else $error("low address bits changed by relocation");

  // page table and control register port
  base_wr_a: assert property (
    (reg_we_i && (reg_addr_i < 8'(`PARU_BASE_OFF + `PARU_NUM_PAGES))) |=>
      (entry_w[$past(6'(reg_addr_i - `PARU_BASE_OFF))].base == $past(reg_wdata_i[11:0])))
    else $error("page base write did not land");

  base_rd_a: assert property (
    (reg_re_i && (reg_addr_i < 8'(`PARU_BASE_OFF + `PARU_NUM_PAGES))) |=>
      (reg_rdata_o == {4'h0, $past(entry_w[6'(reg_addr_i - `PARU_BASE_OFF)].base)}))
    else $error("page base read back wrong");

  desc_wr_a: assert property (
    (reg_we_i && (reg_addr_i >= `PARU_DESC_OFF) && (reg_addr_i < 8'(`PARU_DESC_OFF + `PARU_NUM_PAGES))) |=>
      (entry_w[$past(6'(reg_addr_i - `PARU_DESC_OFF))].key == $past(reg_wdata_i[1:0])))
    else $error("page key write did not land");

  ctrl_rd_a: assert property (
    (reg_re_i && (reg_addr_i == `PARU_CTRL_OFF)) |=> (reg_rdata_o[0] == $past(reloc_en_q)))
    else $error("control read back wrong");

  // access keys, page length and unused mode
  rdonly_read_a: assert property (
    (req_i.valid && reloc_en_q && mode_ok && len_ok && (sel_e.key == `PARU_KEY_RDONLY) && !req_i.write) |=>
      resp_o.valid)
    else $error("read of read-only page was denied");

  xonly_fetch_a: assert property (
    (req_i.valid && reloc_en_q && mode_ok && len_ok && (sel_e.key == `PARU_KEY_XONLY) &&
     req_i.inst && !req_i.write) |=> resp_o.valid)
    else $error("instruction reference to execute-only page was denied");

  xonly_write_a: assert property (
    (req_i.valid && reloc_en_q && (sel_e.key == `PARU_KEY_XONLY) && req_i.write) |=> resp_o.abort)
    else $error("write to execute-only page was not denied");

  rdwr_any_a: assert property (
    (req_i.valid && reloc_en_q && mode_ok && len_ok && (sel_e.key == `PARU_KEY_RDWR)) |=> resp_o.valid)
    else $error("reference to read-write page was denied");

  len_ok_a: assert property (
    (req_i.valid && reloc_en_q && mode_ok && key_ok && (req_i.va[12:6] <= sel_e.len)) |=> resp_o.valid)
    else $error("reference inside page length was denied");

  bad_mode_a: assert property (
    (req_i.valid && reloc_en_q && (req_i.mode == 2'h2)) |=> resp_o.abort)
    else $error("reference in the unused mode was not denied");

  // answers
  answer_once_a: assert property (
    req_i.valid |=> (resp_o.valid || resp_o.abort))
    else $error("reference got no answer");

  resp_quiet_a: assert property (
    !req_i.valid |=> (!resp_o.valid && !resp_o.abort))
    else $error("answer without a reference");

  // page flags
  wr_set_a: assert property (
    (hit && req_i.write) |=> entry_w[$past(sel_idx)].wr)
    else $error("written flag not set by a write");

  no_ref_acc_a: assert property (
    (!hit && !desc_we[sel_idx]) |=> (entry_w[$past(sel_idx)].acc == $past(sel_e.acc)))
    else $error("accessed flag changed without a reference");

  no_ref_wr_a: assert property (
    (!hit && !desc_we[sel_idx]) |=> (entry_w[$past(sel_idx)].wr == $past(sel_e.wr)))
    else $error("written flag changed without a reference");
endmodule

// ===== sim/paru_cpu_model.sv
module paru_cpu_model
  import paru_pkg::*;
(
  input  wire logic core_clk_i,
  input  paru_resp_t resp_i,
  output paru_req_t  req_o
);
  timeunit 1ns;
  timeprecision 1ps;

  initial begin
    req_o = '0;
  end

  // one reference per call; the answer is caught in the cycle after the taking edge
  task automatic issue(input logic [15:0] va, input logic [1:0] mode, input logic write,
                       input logic inst, output paru_resp_t rsp);
    @(posedge core_clk_i);
    req_o.valid <= 1'b1;
    req_o.va    <= va;
    req_o.mode  <= mode;
    req_o.write <= write;
    req_o.inst  <= inst;
    @(posedge core_clk_i);
    req_o.valid <= 1'b0;
    // idle address must not keep showing the last value
    req_o.va    <= ~va;
    #1;
    rsp = resp_i;
  endtask
endmodule

// ===== sim/test_paru_top.sv
`include "paru_regs.svh"

module test_paru_top
  import paru_pkg::*;
();
  timeunit 1ns;
  timeprecision 1ps;

  logic        core_clk;
  logic        resetn;
  paru_req_t   req;
  paru_resp_t  resp;
  logic [7:0]  reg_addr;
  logic [15:0] reg_wdata;
  logic        reg_we;
  logic        reg_re;
  logic [15:0] reg_rdata;
  int          miscompares;
  int          n_tests;
  int          cycles;

  paru_top dut_u (.core_clk_i(core_clk), .resetn_i(resetn), .req_i(req), .resp_o(resp),
                  .reg_addr_i(reg_addr), .reg_wdata_i(reg_wdata), .reg_we_i(reg_we),
                  .reg_re_i(reg_re), .reg_rdata_o(reg_rdata));
  paru_cpu_model cpu_u (.core_clk_i(core_clk), .resp_i(resp), .req_o(req));

  always #10 core_clk = ~core_clk;

  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 20000) begin
      miscompares++;
      stop_test();
    end
  end

  task automatic stop_test();
    if (miscompares == 0 && n_tests > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  task automatic chk(input logic [19:0] got, input logic [19:0] exp);
    n_tests++;
    if (got !== exp) begin
      miscompares++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic reg_wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge core_clk);
    reg_we    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge core_clk);
    reg_we <= 1'b0;
  endtask

  task automatic reg_chk(input logic [7:0] a, input logic [15:0] exp);
    @(posedge core_clk);
    reg_re   <= 1'b1;
    reg_addr <= a;
    @(posedge core_clk);
    reg_re <= 1'b0;
    #1;
    chk({4'h0, reg_rdata}, {4'h0, exp});
  endtask

  task automatic set_page(input logic [7:0] i, input logic [11:0] base, input logic [6:0] len,
                          input logic [1:0] key);
    reg_wr(`PARU_BASE_OFF + i, {4'h0, base});
    reg_wr(`PARU_DESC_OFF + i, {1'b0, len, 6'h00, key});
  endtask

  // ok: expect a forwarded reference at pa; otherwise expect an abort
  task automatic ref_chk(input logic [15:0] va, input logic [1:0] mode, input logic wr,
                         input logic inst, input logic ok, input logic [17:0] pa);
    paru_resp_t r;
    cpu_u.issue(va, mode, wr, inst, r);
    if (ok) begin
      chk(r, {2'b10, pa});
    end else begin
      chk({18'h0, r.valid, r.abort}, 20'h1);
    end
  endtask

  task automatic t_reset();
    reg_chk(`PARU_CTRL_OFF, 16'h0000);
    reg_chk(`PARU_DESC_OFF, 16'h0000);
    reg_chk(`PARU_BASE_OFF + 8'h2f, 16'h0000);
    reg_chk(8'hff, 16'h0000);
    reg_wr(8'hff, 16'hffff);
    reg_chk(8'hff, 16'h0000);
  endtask

  task automatic t_disabled();
    ref_chk(16'hf123, `PARU_MODE_USER, 1'b1, 1'b0, 1'b1, 18'h0f123);
  endtask

  task automatic t_reloc();
    reg_wr(`PARU_CTRL_OFF, 16'h0001);
    set_page(8'd0, 12'hfff, 7'h7f, `PARU_KEY_RDWR);
    set_page(8'd8, 12'h100, 7'h7f, `PARU_KEY_RDWR);
    set_page(8'd15, 12'h001, 7'h7f, `PARU_KEY_RDWR);
    set_page(8'd34, 12'h200, 7'h7f, `PARU_KEY_RDWR);
    ref_chk(16'h0002, `PARU_MODE_KERNEL, 1'b0, 1'b1, 1'b1, 18'h3ffc2);
    ref_chk(16'h1fff, `PARU_MODE_KERNEL, 1'b0, 1'b1, 1'b1, 18'h01fbf);
    ref_chk(16'h0005, `PARU_MODE_KERNEL, 1'b0, 1'b0, 1'b1, 18'h04005);
    ref_chk(16'he000, `PARU_MODE_KERNEL, 1'b0, 1'b0, 1'b1, 18'h00040);
    ref_chk(16'h4003, `PARU_MODE_USER, 1'b0, 1'b1, 1'b1, 18'h08003);
    ref_chk(16'h4003, `PARU_MODE_SUPER, 1'b0, 1'b1, 1'b0, 18'h0);
    // lands on an open user page, so only the mode can deny it
    ref_chk(16'h4002, 2'h2, 1'b0, 1'b1, 1'b0, 18'h0);
    reg_chk(`PARU_STAT_OFF, 16'h0003);
    reg_chk(`PARU_CTRL_OFF, 16'h0001);
  endtask

  task automatic t_keys();
    logic       ok_r;
    logic       ok_w;
    logic       ok_i;
    logic [1:0] k;
    for (int n = 0; n < 4; n++) begin
      k = n[1:0];
      ok_i = (k != `PARU_KEY_NONRES);
      ok_r = (k == `PARU_KEY_RDONLY) || (k == `PARU_KEY_RDWR);
      ok_w = (k == `PARU_KEY_RDWR);
      set_page(8'd1, 12'h010, 7'h7f, k);
      set_page(8'd9, 12'h020, 7'h7f, k);
      ref_chk(16'h2004, `PARU_MODE_KERNEL, 1'b0, 1'b1, ok_i, 18'h00404);
      ref_chk(16'h2004, `PARU_MODE_KERNEL, 1'b0, 1'b0, ok_r, 18'h00804);
      ref_chk(16'h2004, `PARU_MODE_KERNEL, 1'b1, 1'b0, ok_w, 18'h00804);
      reg_chk(`PARU_DESC_OFF + 8'd1, {1'b0, 7'h7f, 1'b0, ok_i, 4'h0, k});
      reg_chk(`PARU_DESC_OFF + 8'd9, {1'b0, 7'h7f, ok_w, ok_r, 4'h0, k});
    end
  endtask

  task automatic t_len();
    set_page(8'd10, 12'h030, 7'h00, `PARU_KEY_RDWR);
    ref_chk(16'h403f, `PARU_MODE_KERNEL, 1'b0, 1'b0, 1'b1, 18'h00c3f);
    ref_chk(16'h4040, `PARU_MODE_KERNEL, 1'b0, 1'b0, 1'b0, 18'h0);
    reg_chk(`PARU_DESC_OFF + 8'd10, {1'b0, 7'h00, 2'b01, 4'h0, `PARU_KEY_RDWR});
    reg_chk(`PARU_STAT_OFF, 16'h0005);
    set_page(8'd10, 12'h030, 7'h7f, `PARU_KEY_RDWR);
    ref_chk(16'h5fff, `PARU_MODE_KERNEL, 1'b1, 1'b0, 1'b1, 18'h02bff);
  endtask

  // reset in mid-run clears flags and relocation enable
  task automatic t_rst_mid();
    @(posedge core_clk);
    resetn <= 1'b0;
    repeat (2) @(posedge core_clk);
    resetn <= 1'b1;
    reg_chk(`PARU_CTRL_OFF, 16'h0000);
    reg_chk(`PARU_DESC_OFF + 8'd9, 16'h0000);
    ref_chk(16'h2004, `PARU_MODE_KERNEL, 1'b0, 1'b0, 1'b1, 18'h02004);
  endtask

  initial begin
    core_clk    = 1'b0;
    resetn      = 1'b0;
    reg_addr    = 8'h00;
    reg_wdata   = 16'h0000;
    reg_we      = 1'b0;
    reg_re      = 1'b0;
    miscompares = 0;
    n_tests     = 0;
    cycles      = 0;
    repeat (16) @(posedge core_clk);
    resetn <= 1'b1;
    t_reset();
    t_disabled();
    t_reloc();
    t_keys();
    t_len();
    t_rst_mid();
    stop_test();
  end
endmodule
